//--- rtl/video_switch_mode_control.sv
// mode, power-down and source selection control of the 7:2 switch
`timescale 1ns/1ps
`default_nettype none
module video_switch_mode_control
    import vswitch_pkg::*;
(
    // clock, reset, enable
    input  wire logic        clock_in,
    input  wire logic        arst_n_in,
    input  wire logic        clk_en_in,
    // pins from the host
    input  wire logic        power_down_n_in,
    input  wire logic        parallel_mode_in,
    input  wire logic [2:0]  out1_source_select_in,
    input  wire logic [2:0]  out2_source_select_in,
    // register write port from the serial engine
    input  wire logic        reg_wr_in,
    input  wire logic        reg_addr_in,
    input  wire logic [2:0]  reg_wdata_in,
    // channel one
    output logic [2:0]       video_out_one_sel_out,
    output logic             neg_rail_one_en_out,
    output logic             video_out_one_gnd_out,
    // channel two
    output logic [2:0]       video_out_two_sel_out,
    output logic             neg_rail_two_en_out,
    output logic             video_out_two_gnd_out,
    // status
    output logic             power_down_out,
    output logic             serial_mode_out,
    output logic [2:0]       out1_field_out,
    output logic [2:0]       out2_field_out
);
    // reset release and pin synchronisers
    logic       rst_meta_ff;
    logic       rst_sync_ff;
    logic [1:0] pd_sync_ff;
    logic [1:0] ps_sync_ff;
    logic [2:0] s1_meta_ff;
    logic [2:0] s1_sync_ff;
    logic [2:0] s2_meta_ff;
    logic [2:0] s2_sync_ff;
    // selection register fields
    logic [2:0] field1_ff;
    logic [2:0] nxt_field1;
    logic [2:0] field2_ff;
    logic [2:0] nxt_field2;
    // decoded mode and per-channel controls
    logic [2:0] code1;
    logic [2:0] code2;
    logic [2:0] sel1;
    logic [2:0] sel2;
    logic       power_on;
    logic       serial_mode;
    logic       rail1;
    logic       rail2;
    logic       gnd1;
    logic       gnd2;
    // output registers and their next values
    logic [2:0] osel1_ff;
    logic [2:0] nxt_osel1;
    logic [2:0] osel2_ff;
    logic [2:0] nxt_osel2;
    logic       orail1_ff;
    logic       nxt_orail1;
    logic       orail2_ff;
    logic       nxt_orail2;
    logic       ognd1_ff;
    logic       nxt_ognd1;
    logic       ognd2_ff;
    logic       nxt_ognd2;
    logic       opd_ff;
    logic       nxt_opd;
    logic       oser_ff;
    logic       nxt_oser;

    // reset release through two flops
    always_ff @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rst_meta_ff <= 1'b0;
            rst_sync_ff <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_sync_ff <= rst_meta_ff;
        end
    end

    // pin synchronisers
    always_ff @(posedge clock_in or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            pd_sync_ff <= 2'h0;
            ps_sync_ff <= 2'h0;
            s1_meta_ff <= 3'h0;
            s1_sync_ff <= 3'h0;
            s2_meta_ff <= 3'h0;
            s2_sync_ff <= 3'h0;
        end else if (clk_en_in) begin
            pd_sync_ff <= {pd_sync_ff[0], power_down_n_in};
            ps_sync_ff <= {ps_sync_ff[0], parallel_mode_in};
            s1_meta_ff <= out1_source_select_in;
            s1_sync_ff <= s1_meta_ff;
            s2_meta_ff <= out2_source_select_in;
            s2_sync_ff <= s2_meta_ff;
        end
    end

    assign power_on    = pd_sync_ff[1];
    assign serial_mode = !ps_sync_ff[1];

    // register fields: cleared in power-down, written only in serial mode
    always_comb begin
        nxt_field1 = field1_ff;
        nxt_field2 = field2_ff;
        if (!power_on) begin
            nxt_field1 = SEL_RESET_VAL;
            nxt_field2 = SEL_RESET_VAL;
        end else if (reg_wr_in && serial_mode) begin
            if (!reg_addr_in)
                nxt_field1 = reg_wdata_in;
            else
                nxt_field2 = reg_wdata_in;
        end
    end

    always_ff @(posedge clock_in or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            field1_ff <= SEL_RESET_VAL;
            field2_ff <= SEL_RESET_VAL;
        end else if (clk_en_in) begin
            field1_ff <= nxt_field1;
            field2_ff <= nxt_field2;
        end
    end

    // source code per mode; pins ignored in serial mode
    always_comb begin
        if (serial_mode) begin
            code1 = field1_ff;
            code2 = field2_ff;
        end else begin
            code1 = s1_sync_ff;
            code2 = s2_sync_ff;
        end
    end

    chan_decode u_ch1 (
        .code_in     (code1),
        .power_on_in (power_on),
        .mux_sel_out (sel1),
        .rail_en_out (rail1),
        .ground_out  (gnd1)
    );

    chan_decode u_ch2 (
        .code_in     (code2),
        .power_on_in (power_on),
        .mux_sel_out (sel2),
        .rail_en_out (rail2),
        .ground_out  (gnd2)
    );

    // next output values; held while the enable is low
    always_comb begin
        nxt_osel1  = osel1_ff;
        nxt_osel2  = osel2_ff;
        nxt_orail1 = orail1_ff;
        nxt_orail2 = orail2_ff;
        nxt_ognd1  = ognd1_ff;
        nxt_ognd2  = ognd2_ff;
        nxt_opd    = opd_ff;
        nxt_oser   = oser_ff;
        if (clk_en_in) begin
            nxt_osel1  = sel1;
            nxt_osel2  = sel2;
            nxt_orail1 = rail1;
            nxt_orail2 = rail2;
            nxt_ognd1  = gnd1;
            nxt_ognd2  = gnd2;
            nxt_opd    = !power_on;
            nxt_oser   = serial_mode;
        end
    end

    // output registers
    always_ff @(posedge clock_in or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            osel1_ff  <= SEL_OFF;
            osel2_ff  <= SEL_OFF;
            orail1_ff <= 1'b0;
            orail2_ff <= 1'b0;
            ognd1_ff  <= 1'b1;
            ognd2_ff  <= 1'b1;
            opd_ff    <= 1'b1;
            oser_ff   <= 1'b0;
        end else begin
            osel1_ff  <= nxt_osel1;
            osel2_ff  <= nxt_osel2;
            orail1_ff <= nxt_orail1;
            orail2_ff <= nxt_orail2;
            ognd1_ff  <= nxt_ognd1;
            ognd2_ff  <= nxt_ognd2;
            opd_ff    <= nxt_opd;
            oser_ff   <= nxt_oser;
        end
    end

    assign video_out_one_sel_out = osel1_ff;
    assign neg_rail_one_en_out   = orail1_ff;
    assign video_out_one_gnd_out = ognd1_ff;
    assign video_out_two_sel_out = osel2_ff;
    assign neg_rail_two_en_out   = orail2_ff;
    assign video_out_two_gnd_out = ognd2_ff;
    assign power_down_out        = opd_ff;
    assign serial_mode_out       = oser_ff;
    assign out1_field_out        = field1_ff;
    assign out2_field_out        = field2_ff;

    // checks: power-down
    chk_pd_grounds: assert property (@(posedge clock_in)
        disable iff (!rst_sync_ff)
        clk_en_in && !power_on |=> ognd1_ff && ognd2_ff
            && !orail1_ff && !orail2_ff)
        else $error("outputs not grounded in power-down");
    chk_pd_sel_off: assert property (@(posedge clock_in)
        disable iff (!rst_sync_ff)
        clk_en_in && !power_on |=> osel1_ff == 3'h0
            && osel2_ff == 3'h0)
        else $error("mux selects not off in power-down");
    chk_pd_status: assert property (@(posedge clock_in)
        disable iff (!rst_sync_ff)
        clk_en_in |=> power_down_out == !$past(power_on))
        else $error("power-down status wrong");
    chk_pd_clears: assert property (@(posedge clock_in)
        disable iff (!rst_sync_ff)
        clk_en_in && !power_on |=> field1_ff == 3'h0
            && field2_ff == 3'h0)
        else $error("fields not cleared by power-down");

    // checks: mode and register fields
    chk_mode_status: assert property (@(posedge clock_in)
        disable iff (!rst_sync_ff)
        clk_en_in |=> serial_mode_out == !$past(ps_sync_ff[1]))
        else $error("mode status wrong");
    chk_par_nowrite: assert property (@(posedge clock_in)
        disable iff (!rst_sync_ff)
        clk_en_in && power_on && !serial_mode |=> $stable(field1_ff)
            && $stable(field2_ff))
        else $error("field written in parallel mode");
    chk_ser_wr_one: assert property (@(posedge clock_in)
        disable iff (!rst_sync_ff)
        clk_en_in && power_on && serial_mode && reg_wr_in && !reg_addr_in
            |=> field1_ff == $past(reg_wdata_in))
        else $error("channel one field write lost");
    chk_ser_wr_two: assert property (@(posedge clock_in)
        disable iff (!rst_sync_ff)
        clk_en_in && power_on && serial_mode && reg_wr_in && reg_addr_in
            |=> field2_ff == $past(reg_wdata_in))
        else $error("channel two field write lost");

    // checks: parallel mode
    chk_par_one: assert property (@(posedge clock_in)
        disable iff (!rst_sync_ff)
        clk_en_in && power_on && !serial_mode
            |=> osel1_ff == $past(s1_sync_ff))
        else $error("channel one pin code not routed");
    chk_par_two: assert property (@(posedge clock_in)
        disable iff (!rst_sync_ff)
        clk_en_in && power_on && !serial_mode
            |=> osel2_ff == $past(s2_sync_ff))
        else $error("channel two pin code not routed");
    chk_rail_one: assert property (@(posedge clock_in)
        disable iff (!rst_sync_ff)
        clk_en_in && power_on && !serial_mode
            |=> orail1_ff == ($past(s1_sync_ff) != 3'h0))
        else $error("channel one rail wrong");
    chk_rail_two: assert property (@(posedge clock_in)
        disable iff (!rst_sync_ff)
        clk_en_in && power_on && !serial_mode
            |=> orail2_ff == ($past(s2_sync_ff) != 3'h0))
        else $error("channel two rail wrong");
    chk_gnd_one: assert property (@(posedge clock_in)
        disable iff (!rst_sync_ff)
        clk_en_in && power_on && !serial_mode
            |=> ognd1_ff == ($past(s1_sync_ff) == 3'h0))
        else $error("channel one ground wrong");
    chk_gnd_two: assert property (@(posedge clock_in)
        disable iff (!rst_sync_ff)
        clk_en_in && power_on && !serial_mode
            |=> ognd2_ff == ($past(s2_sync_ff) == 3'h0))
        else $error("channel two ground wrong");

    // checks: serial mode
    chk_ser_one: assert property (@(posedge clock_in)
        disable iff (!rst_sync_ff)
        clk_en_in && power_on && serial_mode
            |=> osel1_ff == $past(field1_ff)
            && ognd1_ff == ($past(field1_ff) == 3'h0))
        else $error("channel one field not routed");
    chk_ser_two: assert property (@(posedge clock_in)
        disable iff (!rst_sync_ff)
        clk_en_in && power_on && serial_mode
            |=> osel2_ff == $past(field2_ff)
            && ognd2_ff == ($past(field2_ff) == 3'h0))
        else $error("channel two field not routed");
    chk_ser_rail_one: assert property (@(posedge clock_in)
        disable iff (!rst_sync_ff)
        clk_en_in && power_on && serial_mode
            |=> orail1_ff == ($past(field1_ff) != 3'h0))
        else $error("channel one rail wrong in serial mode");
    chk_ser_rail_two: assert property (@(posedge clock_in)
        disable iff (!rst_sync_ff)
        clk_en_in && power_on && serial_mode
            |=> orail2_ff == ($past(field2_ff) != 3'h0))
        else $error("channel two rail wrong in serial mode");
endmodule
`default_nettype wire

//--- common/vswitch_pkg.sv
// constants and types for the video switch mode control
//
// Overview of operation
// - power-down low grounds both outputs and both negative rails, any selection
// - power-down low resets both selection register fields to their default
// - mode pin high selects parallel mode; serial register writes are refused
// - parallel: output one code from pins, zero off, one to seven inputs
// - parallel: output two code decoded the same from its own pins
// - parallel, powered: channel one code zero disables rail, grounds output
// - parallel, powered: channel two code zero disables rail, grounds output
// - mode pin low selects serial mode, selections from register fields
// - serial, powered: channel one field zero grounds output and rail
// - serial, powered: channel two field zero grounds output and rail
// - serial fields use the same code, zero is off and the default
package vswitch_pkg;
    localparam int          CODE_W          = 3;
    localparam logic [2:0]  SEL_OFF         = 3'h0;
    localparam logic [2:0]  SEL_RESET_VAL   = 3'h0;
    localparam int          CLK_PERIOD_NS   = 10;
    localparam int          RESET_PULSE_NS  = 150;
    // least pulse, rounded up to whole cycles
    localparam int          RESET_PULSE_CYC =
        (RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    typedef enum logic [1:0] {
        CH_DOWN,
        CH_OFF,
        CH_ON
    } chan_state_t;
endpackage

//--- rtl/chan_decode.sv
// one output channel: source code to mux select, rail and ground
`timescale 1ns/1ps
`default_nettype none
module chan_decode
    import vswitch_pkg::*;
(
    input  wire logic [2:0] code_in,
    input  wire logic       power_on_in,
    output logic [2:0]      mux_sel_out,
    output logic            rail_en_out,
    output logic            ground_out
);
    // zero code or power-down grounds output and disables the rail
    always_comb begin
        if (!power_on_in) begin
            mux_sel_out = SEL_OFF;
            rail_en_out = 1'b0;
            ground_out  = 1'b1;
        end else if (code_in == SEL_OFF) begin
            mux_sel_out = SEL_OFF;
            rail_en_out = 1'b0;
            ground_out  = 1'b1;
        end else begin
            mux_sel_out = code_in;
            rail_en_out = 1'b1;
            ground_out  = 1'b0;
        end
    end
endmodule
`default_nettype wire

//--- bench/vswitch_host.sv
// host model: strap pins, power-down pulses and register writes
`timescale 1ns/1ps
`default_nettype none
module vswitch_host
    import vswitch_pkg::*;
(
    // clock
    input  wire logic       clock_in,
    // pins and write port towards the block
    output logic            power_down_n_out,
    output logic            parallel_mode_out,
    output logic [2:0]      sel1_out,
    output logic [2:0]      sel2_out,
    output logic            wr_out,
    output logic            addr_out,
    output logic [2:0]      wdata_out
);
    // power comes up with power-down held low
    initial begin
        power_down_n_out  = 1'b0;
        parallel_mode_out = 1'b0;
        sel1_out          = 3'h0;
        sel2_out          = 3'h0;
        wr_out            = 1'b0;
        addr_out          = 1'b0;
        wdata_out         = 3'h0;
    end
    // low for at least the least pulse, left low on return
    task automatic power_down();
        power_down_n_out <= 1'b0;
        repeat (RESET_PULSE_CYC) @(posedge clock_in);
    endtask
    // release, then let the pin syncs settle
    task automatic power_up();
        power_down_n_out <= 1'b1;
        repeat (3) @(posedge clock_in);
    endtask
    // strap mode and select pins, wait out the syncs
    task automatic set_pins(input logic par, input logic [2:0] s1,
                            input logic [2:0] s2);
        parallel_mode_out <= par;
        sel1_out          <= s1;
        sel2_out          <= s2;
        repeat (3) @(posedge clock_in);
    endtask
    // one-cycle write; released lines show the inverse value
    task automatic write_field(input logic a, input logic [2:0] d);
        wr_out    <= 1'b1;
        addr_out  <= a;
        wdata_out <= d;
        @(posedge clock_in);
        wr_out    <= 1'b0;
        addr_out  <= ~a;
        wdata_out <= ~d;
        @(posedge clock_in);
    endtask
endmodule
`default_nettype wire

//--- bench/video_switch_mode_control_tb.sv
// self-checking bench for the mode control, with a reference model
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin comparisons++; if ((e) !== (g)) begin \
    n_fail++; $display("Error %s expected %0h seen %0h", nm, e, g); end end
module video_switch_mode_control_tb;
    import vswitch_pkg::*;
    logic       clock_in = 1'b0;
    logic       arst_n   = 1'b0;
    logic       clk_en   = 1'b1;
    logic       pdn_n, par, wr, addr;
    logic [2:0] s1, s2, wd, sel1, sel2, f1, f2;
    logic       rail1, gnd1, rail2, gnd2, pd, ser;
    logic       m_pdn = 1'b0;
    logic       m_par = 1'b0;
    logic [2:0] m_p1 = 3'h0, m_p2 = 3'h0, m_f1 = 3'h0, m_f2 = 3'h0;
    int         n_fail = 0, comparisons = 0, cycles = 0;
    // clock and timeout
    always #5 clock_in = ~clock_in;
    always @(posedge clock_in) begin
        cycles++;
        if (cycles == 5000) begin
            n_fail++;
            finish_test();
        end
    end
    vswitch_host u_vswitch_host (.clock_in(clock_in),
        .power_down_n_out(pdn_n), .parallel_mode_out(par), .sel1_out(s1),
        .sel2_out(s2), .wr_out(wr), .addr_out(addr), .wdata_out(wd));
    video_switch_mode_control u_video_switch_mode_control (
        .clock_in(clock_in), .arst_n_in(arst_n), .clk_en_in(clk_en),
        .power_down_n_in(pdn_n), .parallel_mode_in(par),
        .out1_source_select_in(s1), .out2_source_select_in(s2),
        .reg_wr_in(wr), .reg_addr_in(addr), .reg_wdata_in(wd),
        .video_out_one_sel_out(sel1), .neg_rail_one_en_out(rail1),
        .video_out_one_gnd_out(gnd1), .video_out_two_sel_out(sel2),
        .neg_rail_two_en_out(rail2), .video_out_two_gnd_out(gnd2),
        .power_down_out(pd), .serial_mode_out(ser),
        .out1_field_out(f1), .out2_field_out(f2));
    // model of one channel: {select, rail, ground}
    function automatic logic [4:0] exp_ch(input logic [2:0] code);
        if (!m_pdn || code == SEL_OFF)
            return {3'h0, 1'b0, 1'b1};
        return {code, 1'b1, 1'b0};
    endfunction
    // let outputs settle, then compare every result
    task automatic check_all();
        repeat (4) @(posedge clock_in);
        #1;
        `CHK("ch1", exp_ch(m_par ? m_p1 : m_f1), {sel1, rail1, gnd1})
        `CHK("ch2", exp_ch(m_par ? m_p2 : m_f2), {sel2, rail2, gnd2})
        `CHK("field1", m_f1, f1)
        `CHK("field2", m_f2, f2)
        `CHK("status", {~m_pdn, ~m_par}, {pd, ser})
        @(posedge clock_in);
    endtask
    task automatic pins(input logic p, input logic [2:0] a, b);
        m_par = p;
        m_p1  = a;
        m_p2  = b;
        u_vswitch_host.set_pins(p, a, b);
    endtask
    // power-down pulse, checked while still low
    task automatic pdown();
        m_pdn = 1'b0;
        m_f1  = SEL_RESET_VAL;
        m_f2  = SEL_RESET_VAL;
        u_vswitch_host.power_down();
        check_all();
        m_pdn = 1'b1;
        u_vswitch_host.power_up();
    endtask
    task automatic wr_f(input logic a, input logic [2:0] d);
        if (!m_par && m_pdn) begin
            if (a) m_f2 = d;
            else m_f1 = d;
        end
        u_vswitch_host.write_field(a, d);
    endtask
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // every code in both modes, refused writes, ignored pins
    initial begin
        void'($urandom(29));
        repeat (3) @(posedge clock_in);
        arst_n <= 1'b1;
        repeat (4) @(posedge clock_in);
        pdown();
        for (int c = 0; c < 8; c++) begin
            pins(1'b1, 3'(c), 3'(7 - c));
            if (c == 4) pdown();
            check_all();
            wr_f(1'b0, 3'($urandom));
            wr_f(1'b1, 3'($urandom));
            check_all();
            pins(1'b0, 3'($urandom), 3'($urandom));
            wr_f(1'b0, 3'(c));
            wr_f(1'b1, 3'(7 - c));
            check_all();
            pins(1'b0, 3'($urandom), 3'($urandom));
            check_all();
        end
        // frozen state ignores pin changes until the enable returns
        clk_en <= 1'b0;
        u_vswitch_host.set_pins(1'b1, 3'h5, 3'h2);
        check_all();
        clk_en <= 1'b1;
        pins(1'b1, 3'h5, 3'h2);
        check_all();
        pdown();
        check_all();
        finish_test();
    end
endmodule
`default_nettype wire
